// >>> logic/smpwm_core.v
// Switch-mode PWM slice: control, steering, dead band and period sync
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "smpwm_regs.vh"

module smpwm_core #(
  parameter TW = 16,
  parameter DBW = 8,
  parameter NSRC = 3
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [15:0] reg_rdata,
  // Peer synchronization
  input wire [NSRC-1:0] sync_in,
  output wire sync_out,
  // Pulse-skip request pin
  input wire skip_request,
  // Power stage outputs
  output wire pwm_output_a,
  output wire pwm_output_b,
  output wire pwm_output_c,
  output wire pwm_output_d,
  output wire pwm_output_e,
  output wire pwm_output_f
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Dead-band counter: runs while the level is high, holds at the limit
  function [DBW-1:0] f_db_next;
    input lvl;
    input [DBW-1:0] cnt;
    input [DBW-1:0] lim;
    begin
      if (!lvl)
        f_db_next = {DBW{1'b0}};
      else if (cnt == lim)
        f_db_next = cnt;
      else
        f_db_next = cnt + {{(DBW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Selected peer sync line, 0 means none
  function f_sync_pick;
    input [NSRC-1:0] vec;
    input [1:0] sel;
    integer i;
    begin
      f_sync_pick = 1'b0;
      for (i = 0; i < NSRC; i = i + 1) begin
        if (sel == i[1:0] + 2'h1)
          f_sync_pick = vec[i];
      end
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg en_ff;
  reg ld_ff;
  reg dbfe_ff;
  reg dbre_ff;
  reg [3:0] mode_ff;
  reg [5:0] steer_ff;
  reg [1:0] ssel_ff;
  reg pofst_ff;
  reg [TW-1:0] per_buf_ff;
  reg [TW-1:0] ph_buf_ff;
  reg [TW-1:0] dc_buf_ff;
  reg [TW-1:0] per_ff;
  reg [TW-1:0] ph_ff;
  reg [TW-1:0] dc_ff;
  reg [DBW-1:0] dbr_lim_ff;
  reg [DBW-1:0] dbf_lim_ff;
  reg [TW-1:0] period_timer_ff;
  reg base_ff;
  reg alt_ff;
  reg skip_lat_ff;
  reg skip_m_ff;
  reg skip_s_ff;
  reg rise_dly_ff;
  reg sync_out_ff;
  reg [DBW-1:0] rcnt_ff;
  reg [DBW-1:0] fcnt_ff;
  reg [5:0] out_ff;
  reg [15:0] rdata_ff;
  reg [5:0] nxt_out;
  reg [15:0] nxt_rdata;
  reg nxt_base;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == `SMPWM_OFS_CTRL);
  wire slave = (ssel_ff != `SMPWM_SYNC_NONE);
  wire sync_hit = f_sync_pick(sync_in, ssel_ff);
  wire own_evt = (period_timer_ff == per_ff);
  wire period_evt = en_ff && (slave ? sync_hit : own_evt);
  wire rise_evt = en_ff && (period_timer_ff == ph_ff);
  wire fall_evt = en_ff && (period_timer_ff == dc_ff);
  wire load_done = ld_ff && (period_evt || !en_ff);
  wire fixed_mode = (mode_ff == `SMPWM_MODE_FIX_SINGLE) ||
                    (mode_ff == `SMPWM_MODE_FIX_COMP);
  wire skip_mode = (mode_ff == `SMPWM_MODE_SKIP) ||
                   (mode_ff == `SMPWM_MODE_SKIP_COMP);
  // Offset set: period event starts drive so duty can reach full period
  wire start_evt = pofst_ff ? period_evt : rise_evt;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      en_ff <= 1'b0;
      dbfe_ff <= 1'b0;
      dbre_ff <= 1'b0;
      mode_ff <= 4'h0;
      steer_ff <= `SMPWM_RST_STEER;
      ssel_ff <= 2'h0;
      pofst_ff <= 1'b0;
      per_buf_ff <= {TW{1'b0}};
      ph_buf_ff <= {TW{1'b0}};
      dc_buf_ff <= {TW{1'b0}};
      dbr_lim_ff <= {DBW{1'b0}};
      dbf_lim_ff <= {DBW{1'b0}};
    end else if (reg_wr) begin
      case (reg_addr)
        `SMPWM_OFS_CTRL: begin
          en_ff <= reg_wdata[`SMPWM_CTRL_EN];
          dbfe_ff <= reg_wdata[`SMPWM_CTRL_DBFE];
          dbre_ff <= reg_wdata[`SMPWM_CTRL_DBRE];
          mode_ff <= reg_wdata[`SMPWM_CTRL_MODE_HI:`SMPWM_CTRL_MODE_LO];
        end
        `SMPWM_OFS_STEER: steer_ff <= reg_wdata[5:0];
        `SMPWM_OFS_SYNC: begin
          ssel_ff <= reg_wdata[`SMPWM_SYNC_SEL_HI:`SMPWM_SYNC_SEL_LO];
          pofst_ff <= reg_wdata[`SMPWM_SYNC_POFST];
        end
        `SMPWM_OFS_PERIOD: per_buf_ff <= reg_wdata[TW-1:0];
        `SMPWM_OFS_PHASE: ph_buf_ff <= reg_wdata[TW-1:0];
        `SMPWM_OFS_DUTY: dc_buf_ff <= reg_wdata[TW-1:0];
        `SMPWM_OFS_DBRISE: dbr_lim_ff <= reg_wdata[DBW-1:0];
        `SMPWM_OFS_DBFALL: dbf_lim_ff <= reg_wdata[DBW-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Buffer load handshake
  // ----------------------------------------
  // A fresh request in the clearing cycle wins and is served again
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ld_ff <= 1'b0;
      per_ff <= {TW{1'b0}};
      ph_ff <= {TW{1'b0}};
      dc_ff <= {TW{1'b0}};
    end else begin
      if (load_done) begin
        per_ff <= per_buf_ff;
        ph_ff <= ph_buf_ff;
        dc_ff <= dc_buf_ff;
      end
      if (wr_ctrl && reg_wdata[`SMPWM_CTRL_LD])
        ld_ff <= 1'b1;
      else if (load_done)
        ld_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Period timer and sync output
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      period_timer_ff <= {TW{1'b0}};
      rise_dly_ff <= 1'b0;
      sync_out_ff <= 1'b0;
    end else begin
      if (!en_ff)
        period_timer_ff <= {TW{1'b0}};
      else if (period_evt)
        period_timer_ff <= {TW{1'b0}};
      else
        period_timer_ff <= period_timer_ff + {{(TW-1){1'b0}}, 1'b1};
      rise_dly_ff <= rise_evt;
      // Extra stage on the rising source gives the two-clock skid
      sync_out_ff <= pofst_ff ? rise_dly_ff : period_evt;
    end
  end

  assign sync_out = sync_out_ff;

  // ----------------------------------------
  // Skip request pin synchronizer
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      skip_m_ff <= 1'b0;
      skip_s_ff <= 1'b0;
    end else begin
      skip_m_ff <= skip_request;
      skip_s_ff <= skip_m_ff;
    end
  end

  // ----------------------------------------
  // Base waveform
  // ----------------------------------------
  always @* begin
    nxt_base = base_ff;
    if (!en_ff)
      nxt_base = 1'b0;
    else if (fixed_mode) begin
      if (period_evt)
        nxt_base = ~base_ff;
    end else if (fall_evt)
      nxt_base = 1'b0;
    else if (start_evt && !(skip_mode && skip_lat_ff))
      nxt_base = 1'b1;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      base_ff <= 1'b0;
      alt_ff <= 1'b0;
      skip_lat_ff <= 1'b0;
    end else begin
      base_ff <= nxt_base;
      if (!en_ff) begin
        alt_ff <= 1'b0;
        skip_lat_ff <= 1'b0;
      end else if (period_evt) begin
        alt_ff <= ~alt_ff;
        skip_lat_ff <= skip_s_ff;
      end
    end
  end

  // ----------------------------------------
  // Dead band
  // ----------------------------------------
  wire comp_lvl = en_ff && !base_ff;
  wire prim = base_ff && (!dbre_ff || rcnt_ff == dbr_lim_ff);
  wire comp = comp_lvl && (!dbfe_ff || fcnt_ff == dbf_lim_ff);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rcnt_ff <= {DBW{1'b0}};
      fcnt_ff <= {DBW{1'b0}};
    end else begin
      rcnt_ff <= f_db_next(base_ff, rcnt_ff, dbr_lim_ff);
      fcnt_ff <= f_db_next(comp_lvl, fcnt_ff, dbf_lim_ff);
    end
  end

  // ----------------------------------------
  // Output steering per mode
  // ----------------------------------------
  // Steering reads the live bits, so a change lands on the next edge
  always @* begin
    nxt_out = 6'h00;
    case (mode_ff)
      `SMPWM_MODE_SINGLE,
      `SMPWM_MODE_FIX_SINGLE,
      `SMPWM_MODE_SKIP:
        nxt_out[0] = prim;
      `SMPWM_MODE_SINGLE_STEER: begin
        nxt_out[0] = steer_ff[0] & prim;
        nxt_out[2] = steer_ff[2] & prim;
        nxt_out[1] = steer_ff[1] & comp;
        nxt_out[3] = steer_ff[3] & comp;
        nxt_out[4] = steer_ff[4] & (steer_ff[5] ? comp : prim);
      end
      `SMPWM_MODE_FIX_COMP,
      `SMPWM_MODE_SKIP_COMP: begin
        nxt_out[0] = prim;
        nxt_out[1] = comp;
      end
      `SMPWM_MODE_PP,
      `SMPWM_MODE_PP_COMP: begin
        nxt_out[0] = prim & ~alt_ff;
        nxt_out[1] = prim & alt_ff;
        if (mode_ff == `SMPWM_MODE_PP_COMP) begin
          nxt_out[2] = comp & ~alt_ff;
          nxt_out[3] = comp & alt_ff;
        end
      end
      `SMPWM_MODE_PP_FB,
      `SMPWM_MODE_PP_FB_COMP: begin
        nxt_out[0] = prim & ~alt_ff;
        nxt_out[1] = prim & alt_ff;
        nxt_out[2] = prim & alt_ff;
        nxt_out[3] = prim & ~alt_ff;
        if (mode_ff == `SMPWM_MODE_PP_FB_COMP) begin
          nxt_out[4] = comp & ~alt_ff;
          nxt_out[5] = comp & alt_ff;
        end
      end
      `SMPWM_MODE_FB_FWD: begin
        nxt_out[0] = en_ff;
        nxt_out[3] = prim;
      end
      `SMPWM_MODE_FB_REV: begin
        nxt_out[2] = en_ff;
        nxt_out[1] = prim;
      end
      `SMPWM_MODE_3PH: begin
        nxt_out[0] = steer_ff[0] & prim;
        nxt_out[1] = steer_ff[1] & comp;
        nxt_out[2] = steer_ff[2] & prim;
        nxt_out[3] = steer_ff[3] & comp;
        nxt_out[4] = steer_ff[4] & prim;
        nxt_out[5] = steer_ff[5] & comp;
      end
      default: nxt_out = 6'h00;
    endcase
    if (!en_ff)
      nxt_out = 6'h00;
  end

  always @(posedge clk or posedge reset) begin
    if (reset)
      out_ff <= 6'h00;
    else
      out_ff <= nxt_out;
  end

  assign pwm_output_a = out_ff[0];
  assign pwm_output_b = out_ff[1];
  assign pwm_output_c = out_ff[2];
  assign pwm_output_d = out_ff[3];
  assign pwm_output_e = out_ff[4];
  assign pwm_output_f = out_ff[5];

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always @* begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      `SMPWM_OFS_CTRL:
        nxt_rdata[7:0] = {en_ff, ld_ff, dbfe_ff, dbre_ff, mode_ff};
      `SMPWM_OFS_STEER: nxt_rdata[5:0] = steer_ff;
      `SMPWM_OFS_SYNC: nxt_rdata[2:0] = {pofst_ff, ssel_ff};
      `SMPWM_OFS_PERIOD: nxt_rdata[TW-1:0] = per_buf_ff;
      `SMPWM_OFS_PHASE: nxt_rdata[TW-1:0] = ph_buf_ff;
      `SMPWM_OFS_DUTY: nxt_rdata[TW-1:0] = dc_buf_ff;
      `SMPWM_OFS_DBRISE: nxt_rdata[DBW-1:0] = dbr_lim_ff;
      `SMPWM_OFS_DBFALL: nxt_rdata[DBW-1:0] = dbf_lim_ff;
      `SMPWM_OFS_TIMER: nxt_rdata[TW-1:0] = period_timer_ff;
      `SMPWM_OFS_STATUS: nxt_rdata[7:0] = {base_ff, alt_ff, out_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset)
      rdata_ff <= 16'h0000;
    else if (reg_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 16'h0000;
  end

  assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

// >>> logic/smpwm_regs.vh
// Register map, field positions and reset values of the switch-mode PWM slice
`ifndef SMPWM_REGS_VH
`define SMPWM_REGS_VH
// ----------------------------------------
// Register word indices
// ----------------------------------------
`define SMPWM_OFS_CTRL 4'h0
`define SMPWM_OFS_STEER 4'h1
`define SMPWM_OFS_SYNC 4'h2
`define SMPWM_OFS_PERIOD 4'h3
`define SMPWM_OFS_PHASE 4'h4
`define SMPWM_OFS_DUTY 4'h5
`define SMPWM_OFS_DBRISE 4'h6
`define SMPWM_OFS_DBFALL 4'h7
`define SMPWM_OFS_TIMER 4'h8
`define SMPWM_OFS_STATUS 4'h9
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SMPWM_CTRL_EN 7
`define SMPWM_CTRL_LD 6
`define SMPWM_CTRL_DBFE 5
`define SMPWM_CTRL_DBRE 4
`define SMPWM_CTRL_MODE_HI 3
`define SMPWM_CTRL_MODE_LO 0
// ----------------------------------------
// Sync control register fields
// ----------------------------------------
`define SMPWM_SYNC_SEL_HI 1
`define SMPWM_SYNC_SEL_LO 0
`define SMPWM_SYNC_POFST 2
`define SMPWM_SYNC_NONE 2'h0
// ----------------------------------------
// Operating modes
// ----------------------------------------
`define SMPWM_MODE_SINGLE 4'h0
`define SMPWM_MODE_SINGLE_STEER 4'h1
`define SMPWM_MODE_PP 4'h2
`define SMPWM_MODE_PP_COMP 4'h3
`define SMPWM_MODE_PP_FB 4'h4
`define SMPWM_MODE_PP_FB_COMP 4'h5
`define SMPWM_MODE_SKIP 4'h6
`define SMPWM_MODE_SKIP_COMP 4'h7
`define SMPWM_MODE_FB_REV 4'h8
`define SMPWM_MODE_FB_FWD 4'h9
`define SMPWM_MODE_FIX_SINGLE 4'ha
`define SMPWM_MODE_FIX_COMP 4'hb
`define SMPWM_MODE_3PH 4'hc
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SMPWM_RST_CTRL 8'h00
`define SMPWM_RST_STEER 6'h00
`define SMPWM_RST_SYNC 3'h0
`endif

// >>> bench/smpwm_core_monitor.sv
// Port checker for the switch-mode PWM core
`timescale 1ns/10ps
`default_nettype none
module smpwm_core_monitor #(
  parameter NSRC = 3
) (
  // Clock, reset and register port
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Sync and drives
  input wire logic [NSRC-1:0] sync_in,
  input wire logic sync_out,
  input wire logic skip_request,
  input wire logic pwm_output_a,
  input wire logic pwm_output_b,
  input wire logic pwm_output_c,
  input wire logic pwm_output_d,
  input wire logic pwm_output_e,
  input wire logic pwm_output_f
);
  logic [7:0] ctrl_ff;
  logic [2:0] sync_ff;
  wire logic [5:0] outs;
  wire logic sw;
  assign outs = {pwm_output_f, pwm_output_e, pwm_output_d, pwm_output_c, pwm_output_b, pwm_output_a};
  assign sw = reg_wr && reg_addr == 4'h1 && (ctrl_ff[3:0] == 4'h1 || ctrl_ff[3:0] == 4'hc);
  // ----
  // Shadow of written control fields
  // ----
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= 8'h00;
      sync_ff <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == 4'h0) begin
        ctrl_ff <= reg_wdata[7:0];
      end
      if (reg_wr && reg_addr == 4'h2) begin
        sync_ff <= reg_wdata[2:0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property ($fell(reset) |-> outs == 6'h00 && !sync_out && reg_rdata == 16'h0000)
    else $error("drives active after reset");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h9 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:8] == 8'h00 &&
    {reg_rdata[7], reg_rdata[5:0]} == {ctrl_ff[7], ctrl_ff[5:0]}) else $error("control readback wrong");
  a_load_clears: assert property ((reg_wr && reg_addr == 4'h0 && reg_wdata[7:6] == 2'b01)
    ##1 !(reg_wr && reg_addr == 4'h0) ##1 (reg_rd && reg_addr == 4'h0) |=> !reg_rdata[6])
    else $error("load request not cleared");
  a_steer_off_a: assert property (sw && !reg_wdata[0] ##1 !(reg_wr && reg_addr == 4'h1) |-> ##1 !pwm_output_a)
    else $error("output a still driven");
  a_steer_off_b: assert property (sw && !reg_wdata[1] ##1 !(reg_wr && reg_addr == 4'h1) |-> ##1 !pwm_output_b)
    else $error("output b still driven");
  a_f_unused: assert property (ctrl_ff[3:0] == 4'h1 && $past(ctrl_ff[3:0]) == 4'h1 |-> !pwm_output_f)
    else $error("output f driven in steering mode");
  a_reserved_dark: assert property (ctrl_ff[3:0] > 4'hc && $past(ctrl_ff[3:0]) > 4'hc |-> outs == 6'h00)
    else $error("reserved mode drives outputs");
  a_slave_follow: assert property (ctrl_ff[7] && sync_ff == 3'h1 && sync_in[0] |=> sync_out)
    else $error("slave missed sync pulse");
  a_slave_quiet: assert property (ctrl_ff[7] && sync_ff == 3'h1 && $past(ctrl_ff[7]) && $past(sync_ff) == 3'h1
    && !$past(sync_in[0]) |-> !sync_out) else $error("slave ran on own period");
  c_load: cover property (reg_wr && reg_addr == 4'h0 && reg_wdata[6]);
  c_slave: cover property (sync_in[0] && sync_ff == 3'h1 ##1 sync_out);
  c_steer: cover property (sw);
endmodule
bind smpwm_core smpwm_core_monitor #(.NSRC(NSRC)) smpwm_core_monitor_inst (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sync_in(sync_in), .sync_out(sync_out), .skip_request(skip_request), .pwm_output_a(pwm_output_a),
  .pwm_output_b(pwm_output_b), .pwm_output_c(pwm_output_c), .pwm_output_d(pwm_output_d),
  .pwm_output_e(pwm_output_e), .pwm_output_f(pwm_output_f));
`default_nettype wire

// >>> bench/smpwm_peer_model.sv
// Peer PWM module model that emits period sync pulses
`timescale 1ns/10ps
`default_nettype none
module smpwm_peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic [1:0] src,
  input wire logic [7:0] gap,
  // Sync lines
  output logic [2:0] sync_vec
);
  logic [7:0] cnt_ff;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 8'h00;
      sync_vec <= 3'h0;
    end else begin
      cnt_ff <= (!run || cnt_ff == gap) ? 8'h00 : cnt_ff + 8'h01;
      // One-cycle pulse on this peer's own line only
      sync_vec <= (run && cnt_ff == gap) ? 3'h1 << src : 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/switch_mode_pwm_sync_steering_test.sv
// Self-checking bench for the switch-mode PWM core
`timescale 1ns/10ps
`default_nettype none
module switch_mode_pwm_sync_steering_test;
  typedef struct {
    logic skip;
    logic [3:0] mode;
    logic [5:0] steer;
    logic [15:0] duty;
    logic [5:0] lvl;
    logic [5:0] mask;
    logic [5:0] chg;
  } smpwm_row_t;
  localparam logic [15:0] F = 16'hffff;
  smpwm_row_t rows [19] = '{'{0, 4'h0, 6'h00, F, 6'h01, 6'h01, 0}, '{0, 4'h1, 6'h3f, F, 6'h05, 6'h3f, 0},
    '{0, 4'h1, 6'h1d, F, 6'h15, 6'h3f, 0}, '{0, 4'h1, 6'h1e, F, 6'h14, 6'h3f, 0},
    '{0, 4'hc, 6'h3f, F, 6'h15, 6'h3f, 0}, '{0, 4'hc, 6'h2a, F, 6'h00, 6'h3f, 0},
    '{0, 4'h9, 6'h00, F, 6'h09, 6'h3f, 0}, '{0, 4'h8, 6'h00, F, 6'h06, 6'h3f, 0},
    '{0, 4'h6, 6'h00, 16'h0002, 6'h00, 6'h00, 16}, '{1, 4'h6, 6'h00, 16'h0002, 6'h00, 6'h01, 0},
    '{0, 4'h7, 6'h00, F, 6'h01, 6'h03, 0}, '{0, 4'h2, 6'h00, F, 6'h00, 6'h00, 8},
    '{0, 4'h3, 6'h00, F, 6'h00, 6'h00, 8}, '{0, 4'h4, 6'h00, F, 6'h00, 6'h00, 8},
    '{0, 4'h5, 6'h00, F, 6'h00, 6'h00, 8}, '{0, 4'ha, 6'h00, F, 6'h00, 6'h00, 8},
    '{0, 4'hb, 6'h00, F, 6'h00, 6'h00, 8}, '{0, 4'hd, 6'h00, F, 6'h00, 6'h3f, 0},
    '{0, 4'hf, 6'h00, F, 6'h00, 6'h3f, 0}};
  logic clk, reset, reg_wr, reg_rd, skip_request, run;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [1:0] src;
  logic [7:0] gap;
  wire logic [15:0] reg_rdata;
  wire logic [2:0] sync_in;
  wire logic sync_out, oa, ob, oc, od, oe, of;
  wire logic [6:0] probe;
  int error_cnt = 0;
  int n_compared = 0;
  int c, d0, d1;
  assign probe = {sync_out, of, oe, od, oc, ob, oa};
  smpwm_core smpwm_core_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_in(sync_in), .sync_out(sync_out),
    .skip_request(skip_request), .pwm_output_a(oa), .pwm_output_b(ob), .pwm_output_c(oc),
    .pwm_output_d(od), .pwm_output_e(oe), .pwm_output_f(of));
  smpwm_peer_model smpwm_peer_model_inst (.clk(clk), .reset(reset), .run(run), .src(src), .gap(gap),
    .sync_vec(sync_in));
  // ----
  // Bus tasks and checks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // Load while disabled so the buffered counts land at once
  task automatic cfg(input logic [15:0] per, input logic [15:0] duty);
    wr(4'h0, 16'h0000);
    wr(4'h3, per);
    wr(4'h4, 16'h0000);
    wr(4'h5, duty);
    wr(4'h0, 16'h0040);
  endtask
  task automatic changes(input int k, input int n, output int cnt);
    logic p;
    cnt = 0;
    @(negedge clk);
    p = probe[k];
    repeat (n) begin
      @(negedge clk);
      if (probe[k] !== p) cnt++;
      p = probe[k];
    end
  endtask
  // Cycles from a sync pulse to the next rise of one drive
  task automatic lag(input int k, output int n);
    int i;
    // Start off the launching edge so no stale output is seen
    @(negedge clk);
    for (i = 0; i < 100 && probe[6] !== 1'b1; i++) @(negedge clk);
    for (n = 0; n < 100 && probe[k] !== 1'b0; n++) @(negedge clk);
    for (; n < 100 && probe[k] !== 1'b1; n++) @(negedge clk);
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    {reset, reg_wr, reg_rd, skip_request, run, reg_addr, reg_wdata, src} = {5'h10, 22'h0};
    gap = 8'h06;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      @(posedge clk);
      skip_request <= rows[i].skip;
      cfg(16'h0003, rows[i].duty);
      wr(4'h0, {12'h008, rows[i].mode});
      wr(4'h1, {10'h000, rows[i].steer});
      rdchk(4'h0, {12'h008, rows[i].mode});
      repeat (16) @(posedge clk);
      changes(0, 32, c);
      chk(16'(c), {10'h000, rows[i].chg});
      chk({10'h000, probe[5:0] & rows[i].mask}, {10'h000, rows[i].lvl});
    end
    @(posedge clk);
    skip_request <= 1'b0;
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a < 3; a++) rdchk(4'(a), 16'h0000);
    wr(4'ha, 16'hffff);
    rdchk(4'ha, 16'h0000);
    wr(4'h0, 16'h0040);
    rdchk(4'h0, 16'h0000);
    cfg(16'h0009, 16'h0006);
    wr(4'h0, 16'h0080);
    lag(0, d0);
    wr(4'h6, 16'h0003);
    wr(4'h0, 16'h0090);
    lag(0, d1);
    chk(16'(d1 - d0), 16'h0003);
    wr(4'h1, 16'h0002);
    wr(4'h0, 16'h0081);
    lag(1, d0);
    wr(4'h7, 16'h0002);
    wr(4'h0, 16'h00a1);
    lag(1, d1);
    chk(16'(d1 - d0), 16'h0002);
    wr(4'h2, 16'h0004);
    // Let the old sync source drain before counting
    @(posedge clk);
    changes(6, 70, c);
    chk(16'(c), 16'h000e);
    run <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      src <= 2'(s - 1);
      wr(4'h2, 16'(s));
      @(posedge clk);
      changes(6, 70, c);
      chk(16'(c), 16'h0014);
    end
    src <= 2'h0;
    wr(4'h2, 16'h0002);
    @(posedge clk);
    changes(6, 70, c);
    chk(16'(c), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
